//--- include/asp9_pkg.sv
// Purpose: shared constants and types of the 9-bit async serial port
// Assumes: word-indexed registers, byte address = 4 * index
// Notes: all offsets and field positions, and the reload and byte reset values, live here
package asp9_pkg;
	localparam int ASP9_IDX_W = 10;
	localparam logic [9:0] ASP9_CTRL_IDX = 10'h098;
	localparam logic [9:0] ASP9_DATA_IDX = 10'h099;
	localparam logic [9:0] ASP9_RELOAD_IDX = 10'h09a;
	localparam logic [9:0] ASP9_TMRCTL_IDX = 10'h09b;
	localparam int ASP9_MODE_BIT = 7;
	localparam int ASP9_UNUSED_BIT = 6;
	localparam int ASP9_MCE_BIT = 5;
	localparam int ASP9_REN_BIT = 4;
	localparam int ASP9_TB8_BIT = 3;
	localparam int ASP9_RB8_BIT = 2;
	localparam int ASP9_TI_BIT = 1;
	localparam int ASP9_RI_BIT = 0;
	localparam int ASP9_RUN_BIT = 0;
	localparam logic [7:0] ASP9_RELOAD_RST = 8'h00;
	localparam logic [7:0] ASP9_BYTE_RST = 8'h00;
	localparam logic [3:0] ASP9_FRAME8_BITS = 4'ha;
	localparam logic [3:0] ASP9_FRAME9_BITS = 4'hb;
	localparam logic [3:0] ASP9_DATA_BITS = 4'h8;
	typedef enum logic [2:0] {
		ASP9_RX_IDLE = 3'b000,
		ASP9_RX_START = 3'b001,
		ASP9_RX_DATA = 3'b010,
		ASP9_RX_NINTH = 3'b011,
		ASP9_RX_STOP = 3'b100
	} asp9_rx_state_t;
endpackage

//--- hdl/asp9_bit_timer.sv
// Purpose: 8-bit auto-reload bit timer, one overflow pulse per wrap
// Assumes: counts one per system clock while running
// Notes: force reload restarts the period at once
`timescale 1ns/10ps
module asp9_bit_timer #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic force_i,
	input wire logic [WIDTH-1:0] reload_i,
	output logic ovf_o
);
	logic [WIDTH-1:0] count_q;
	wire wrap = run_i && (count_q == {WIDTH{1'b1}});

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			count_q <= '0;
			ovf_o <= 1'b0;
		end else if (force_i) begin
			count_q <= reload_i;
			ovf_o <= 1'b0;
		end else begin
			if (wrap) begin
				count_q <= reload_i;
			end else if (run_i) begin
				count_q <= count_q + 1'b1;
			end
			ovf_o <= wrap;
		end
	end
endmodule

//--- hdl/asp9_tx_serializer.sv
// Purpose: frame serializer for 10- or 11-bit characters
// Assumes: bit_tick_i is a one-cycle pulse per bit period
// Notes: a load taken while busy or pending is dropped; the line idles high
`timescale 1ns/10ps
module asp9_tx_serializer
	import asp9_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic bit_tick_i,
	input wire logic load_i,
	input wire logic [7:0] data_i,
	input wire logic nine_i,
	input wire logic ninth_i,
	output logic line_o,
	output logic stop_start_o,
	output logic busy_o
);
	logic pend_q;
	logic [7:0] hold_q;
	logic [10:0] shreg_q;
	logic [3:0] left_q;
	wire next_bit = shreg_q[1];

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pend_q <= 1'b0;
			hold_q <= ASP9_BYTE_RST;
			shreg_q <= '1;
			left_q <= '0;
			busy_o <= 1'b0;
			line_o <= 1'b1;
			stop_start_o <= 1'b0;
		end else begin
			stop_start_o <= 1'b0;
			// Byte latched at the write: the bus data is gone by the first bit tick
			if (load_i && !busy_o && !pend_q) begin
				pend_q <= 1'b1;
				hold_q <= data_i;
			end
			if (bit_tick_i && busy_o) begin
				shreg_q <= {1'b1, shreg_q[10:1]};
				left_q <= left_q - 4'h1;
				line_o <= (left_q == 4'h1) ? 1'b1 : next_bit;
				stop_start_o <= (left_q == 4'h2);
				busy_o <= (left_q != 4'h1);
			end else if (bit_tick_i && pend_q) begin
				// Start bit low, LSB first, stop high
				shreg_q <= {1'b1, nine_i ? ninth_i : 1'b1, hold_q, 1'b0};
				left_q <= nine_i ? ASP9_FRAME9_BITS : ASP9_FRAME8_BITS;
				line_o <= 1'b0;
				busy_o <= 1'b1;
				pend_q <= 1'b0;
			end
		end
	end
endmodule

//--- hdl/asp9_top.sv
// Purpose: full-duplex async serial port, 8- or 9-bit frames
// Assumes: classic Wishbone slave, one 20 MHz clock, sync reset
// Notes: bit timer counts system clocks; overflows run at twice baud
// Overview of operation
// - control bit 7 selects 8 or 9-bit frames
// - 8-bit frame: start, eight data LSB-first, stop
// - 8-bit mode stores received stop bit in bit 2
// - writing data buffer starts transmission
// - transmit-done set at stop-bit start
// - receive only while receive enable is set
// - 8-bit accept needs done clear, filter stop high
// - overrun keeps first byte, drops later one
// - 9-bit frame adds ninth bit from bit 3
// - 9-bit mode stores ninth bit, ignores stop
// - 9-bit accept needs done clear, filter ninth high
// - interrupt request when either done flag set
// - done flags cleared only by software writing zero
// - receive-done set when stop bit sampled
// - control bit 6 reads one, writes ignored
// - transmit ninth bit unused in 8-bit mode
// - bit clock is timer overflow divided by two
// - receive timer copy reloaded on start detect
// - data writes go transmit, reads give receive
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
module asp9_top
(
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic irq_enable_i,
	output logic irq_o,
	input wire logic serial_in_pin_i,
	output logic serial_out_pin_o
);
	import asp9_pkg::*;
	// Register state
	logic frame_length_select_q;
	logic multiproc_filter_enable_q;
	logic receive_enable_bit_q;
	logic tx_ninth_bit_q;
	logic rx_ninth_bit_q;
	logic tx_done_flag_q;
	logic rx_done_flag_q;
	logic [7:0] rx_buf_q;
	logic [7:0] bit_timer_reload_q;
	logic timer_run_q;

	// Bus decode
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire lane0 = wb_sel_i[0];
	wire [ASP9_IDX_W-1:0] idx = wb_adr_i[11:2];
	wire hit_ctrl = idx == ASP9_CTRL_IDX;
	wire hit_data = idx == ASP9_DATA_IDX;
	wire hit_reload = idx == ASP9_RELOAD_IDX;
	wire hit_tmrctl = idx == ASP9_TMRCTL_IDX;
	wire wr = req && wb_we_i && lane0;
	wire wr_ctrl = wr && hit_ctrl;
	wire wr_data = wr && hit_data;
	wire [7:0] wbyte = wb_dat_i[7:0];
	wire [7:0] ctrl_view = {frame_length_select_q, 1'b1, multiproc_filter_enable_q,
		receive_enable_bit_q, tx_ninth_bit_q, rx_ninth_bit_q, tx_done_flag_q, rx_done_flag_q};
	wire [7:0] rd_byte = hit_ctrl ? ctrl_view :
		hit_data ? rx_buf_q :
		hit_reload ? bit_timer_reload_q :
		hit_tmrctl ? {7'h00, timer_run_q} : 8'h00;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= {24'h00_0000, rd_byte};
			end
		end
	end
	// Bit timers: tx runs free, rx copy restarts on start detect
	logic tx_ovf;
	logic rx_ovf;
	logic tx_div_q;
	logic rx_phase_q;
	logic start_seen;

	asp9_bit_timer #(.WIDTH(8)) u_tx_timer (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.run_i(timer_run_q),
		.force_i(1'b0),
		.reload_i(bit_timer_reload_q),
		.ovf_o(tx_ovf)
	);
	asp9_bit_timer #(.WIDTH(8)) u_rx_timer (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.run_i(timer_run_q),
		.force_i(start_seen),
		.reload_i(bit_timer_reload_q),
		.ovf_o(rx_ovf)
	);
	wire tx_bit_tick = tx_ovf && tx_div_q;
	// First rx overflow after start is half a bit in: mid-bit sampling
	wire rx_sample = rx_ovf && !rx_phase_q;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			tx_div_q <= 1'b0;
			rx_phase_q <= 1'b0;
		end else begin
			if (tx_ovf) begin
				tx_div_q <= !tx_div_q;
			end
			if (start_seen) begin
				rx_phase_q <= 1'b0;
			end else if (rx_ovf) begin
				rx_phase_q <= !rx_phase_q;
			end
		end
	end
	// Transmitter
	logic tx_stop_start;
	logic tx_busy;

	asp9_tx_serializer u_tx (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.bit_tick_i(tx_bit_tick),
		.load_i(wr_data),
		.data_i(wbyte),
		.nine_i(frame_length_select_q),
		.ninth_i(tx_ninth_bit_q),
		.line_o(serial_out_pin_o),
		.stop_start_o(tx_stop_start),
		.busy_o(tx_busy)
	);
	// Receiver front end; start detect reads both the second and third stages
	logic in_meta_q;
	logic in_sync_q;
	logic in_prev_q;
	asp9_rx_state_t rx_state_q;
	asp9_rx_state_t rx_state_d;
	logic [7:0] rx_shreg_q;
	logic [3:0] rx_cnt_q;
	logic rx_ninth_q;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			in_meta_q <= 1'b1;
			in_sync_q <= 1'b1;
			in_prev_q <= 1'b1;
		end else begin
			in_meta_q <= serial_in_pin_i;
			in_sync_q <= in_meta_q;
			in_prev_q <= in_sync_q;
		end
	end

	wire rx_idle = rx_state_q == ASP9_RX_IDLE;
	assign start_seen = rx_idle && receive_enable_bit_q && in_prev_q && !in_sync_q;
	wire in_stop = rx_state_q == ASP9_RX_STOP;
	wire stop_eval = in_stop && rx_sample;
	wire nine_mode = frame_length_select_q;
	// Stop level in 8-bit mode, ninth data bit in 9-bit mode
	wire rx_tag = nine_mode ? rx_ninth_q : in_sync_q;
	wire rx_accept = stop_eval && !rx_done_flag_q && (!multiproc_filter_enable_q || rx_tag);

	always_comb begin
		rx_state_d = rx_state_q;
		case (rx_state_q)
			ASP9_RX_IDLE: begin
				if (start_seen) begin
					rx_state_d = ASP9_RX_START;
				end
			end
			ASP9_RX_START: begin
				if (rx_sample) begin
					rx_state_d = in_sync_q ? ASP9_RX_IDLE : ASP9_RX_DATA;
				end
			end
			ASP9_RX_DATA: begin
				if (rx_sample && rx_cnt_q == ASP9_DATA_BITS - 4'h1) begin
					rx_state_d = nine_mode ? ASP9_RX_NINTH : ASP9_RX_STOP;
				end
			end
			ASP9_RX_NINTH: begin
				if (rx_sample) begin
					rx_state_d = ASP9_RX_STOP;
				end
			end
			ASP9_RX_STOP: begin
				if (rx_sample) begin
					rx_state_d = ASP9_RX_IDLE;
				end
			end
			default: begin
				rx_state_d = ASP9_RX_IDLE;
			end
		endcase
		// Clearing receive enable abandons a character in flight
		if (!receive_enable_bit_q) begin
			rx_state_d = ASP9_RX_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rx_state_q <= ASP9_RX_IDLE;
			rx_shreg_q <= ASP9_BYTE_RST;
			rx_cnt_q <= 4'h0;
			rx_ninth_q <= 1'b0;
		end else begin
			rx_state_q <= rx_state_d;
			if (rx_state_q == ASP9_RX_START) begin
				rx_cnt_q <= 4'h0;
			end
			if (rx_state_q == ASP9_RX_DATA && rx_sample) begin
				rx_shreg_q <= {in_sync_q, rx_shreg_q[7:1]};
				rx_cnt_q <= rx_cnt_q + 4'h1;
			end
			if (rx_state_q == ASP9_RX_NINTH && rx_sample) begin
				rx_ninth_q <= in_sync_q;
			end
		end
	end
	// Control, flags and data registers
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			frame_length_select_q <= 1'b0;
			multiproc_filter_enable_q <= 1'b0;
			receive_enable_bit_q <= 1'b0;
			tx_ninth_bit_q <= 1'b0;
			rx_ninth_bit_q <= 1'b0;
			tx_done_flag_q <= 1'b0;
			rx_done_flag_q <= 1'b0;
			rx_buf_q <= ASP9_BYTE_RST;
			bit_timer_reload_q <= ASP9_RELOAD_RST;
			timer_run_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				frame_length_select_q <= wbyte[ASP9_MODE_BIT];
				multiproc_filter_enable_q <= wbyte[ASP9_MCE_BIT];
				receive_enable_bit_q <= wbyte[ASP9_REN_BIT];
				tx_ninth_bit_q <= wbyte[ASP9_TB8_BIT];
			end
			if (rx_accept) begin
				rx_ninth_bit_q <= rx_tag;
			end else if (wr_ctrl) begin
				rx_ninth_bit_q <= wbyte[ASP9_RB8_BIT];
			end
			// Hardware set beats a same-cycle software clear
			if (tx_stop_start) begin
				tx_done_flag_q <= 1'b1;
			end else if (wr_ctrl && !wbyte[ASP9_TI_BIT]) begin
				tx_done_flag_q <= 1'b0;
			end
			if (rx_accept) begin
				rx_done_flag_q <= 1'b1;
			end else if (wr_ctrl && !wbyte[ASP9_RI_BIT]) begin
				rx_done_flag_q <= 1'b0;
			end
			if (rx_accept) begin
				rx_buf_q <= rx_shreg_q;
			end
			if (wr && hit_reload) begin
				bit_timer_reload_q <= wbyte;
			end
			if (wr && hit_tmrctl) begin
				timer_run_q <= wbyte[ASP9_RUN_BIT];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= irq_enable_i && (tx_done_flag_q || rx_done_flag_q);
		end
	end

	// Checks
	property p_ack_single;
		@(posedge clk_sys_i) disable iff (sys_rst_i) wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");
	property p_bit6_reads_one;
		@(posedge clk_sys_i) disable iff (sys_rst_i) (req && !wb_we_i && hit_ctrl) |=> wb_dat_o[ASP9_UNUSED_BIT];
	endproperty
	a_bit6_reads_one: assert property (p_bit6_reads_one) else $error("control bit 6 read as 0");
	property p_tx_done_at_stop;
		@(posedge clk_sys_i) disable iff (sys_rst_i) tx_stop_start |-> serial_out_pin_o ##1 tx_done_flag_q;
	endproperty
	a_tx_done_at_stop: assert property (p_tx_done_at_stop) else $error("tx done not at stop bit");
	property p_flag_sticky;
		@(posedge clk_sys_i) disable iff (sys_rst_i) (rx_done_flag_q && !wr_ctrl) |=> rx_done_flag_q;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("rx done dropped without write");
	property p_rx_disabled;
		@(posedge clk_sys_i) disable iff (sys_rst_i) !receive_enable_bit_q |=> rx_idle;
	endproperty
	a_rx_disabled: assert property (p_rx_disabled) else $error("receiver active while disabled");
	property p_overrun_keeps;
		@(posedge clk_sys_i) disable iff (sys_rst_i) (stop_eval && rx_done_flag_q) |=> $stable(rx_buf_q);
	endproperty
	a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun replaced buffer");
	property p_accept_sets;
		@(posedge clk_sys_i) disable iff (sys_rst_i) rx_accept |=> rx_done_flag_q && rx_buf_q == $past(rx_shreg_q);
	endproperty
	a_accept_sets: assert property (p_accept_sets) else $error("accepted char not stored");
	property p_filter8;
		@(posedge clk_sys_i) disable iff (sys_rst_i)
			(stop_eval && !nine_mode && multiproc_filter_enable_q && !in_sync_q && !rx_done_flag_q) |=> !rx_done_flag_q;
	endproperty
	a_filter8: assert property (p_filter8) else $error("bad stop accepted with filter");
	property p_irq;
		@(posedge clk_sys_i) disable iff (sys_rst_i) (irq_enable_i && (tx_done_flag_q || rx_done_flag_q)) |=> irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("irq missing with flag set");
	property p_idle_high;
		@(posedge clk_sys_i) disable iff (sys_rst_i) !tx_busy |-> serial_out_pin_o;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line low while idle");

	c_accept: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) rx_accept);
	c_overrun: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) stop_eval && rx_done_flag_q);
	c_tx_done: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) tx_stop_start && nine_mode);
endmodule

//--- verification/asp9_remote.sv
// Purpose: remote serial transceiver facing the port's line pins
// Assumes: bit period is BIT_CLKS system clocks, line idles high
// Notes: the bench calls send and recv; captured bits are LSB first from start
`timescale 1ns/10ps
module asp9_remote #(
	parameter int BIT_CLKS = 32
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	initial line_o = 1'b1;

	task automatic send(input logic nine, input logic [7:0] d, input logic b9, input logic stop);
		logic [10:0] f;
		f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
		for (int i = 0; i < (nine ? 11 : 10); i++) begin
			@(posedge clk_i);
			line_o <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clk_i);
		end
		@(posedge clk_i);
		line_o <= 1'b1;
		repeat (BIT_CLKS) @(posedge clk_i);
	endtask

	task automatic recv(input logic nine, output logic [10:0] bits);
		int n;
		bits = '1;
		n = 0;
		while (line_i !== 1'b0 && n < 40 * BIT_CLKS) begin
			@(posedge clk_i);
			n++;
		end
		// Mid-bit sampling tolerates a few clocks of start jitter
		repeat (BIT_CLKS / 2) @(posedge clk_i);
		for (int i = 0; i < (nine ? 11 : 10); i++) begin
			bits[i] = line_i;
			repeat (BIT_CLKS) @(posedge clk_i);
		end
	endtask
endmodule

//--- verification/asp9_top_tb.sv
// Purpose: self-checking bench for the 9-bit async serial port
// Assumes: classic Wishbone, ack one cycle after the request is taken
// Notes: reload chosen for a short bit period to keep the run brief
`timescale 1ns/10ps
module asp9_top_tb;
	import asp9_pkg::*;
	localparam logic [7:0] RELOAD = 8'hf0;
	localparam int BIT_CLKS = 2 * (256 - RELOAD);
	localparam logic [11:0] A_CTRL = {ASP9_CTRL_IDX, 2'b00};
	localparam logic [11:0] A_DATA = {ASP9_DATA_IDX, 2'b00};
	localparam logic [11:0] A_RLD = {ASP9_RELOAD_IDX, 2'b00};
	localparam logic [11:0] A_RUN = {ASP9_TMRCTL_IDX, 2'b00};
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic irq_enable_i = 1'b1;
	logic irq_o;
	logic serial_in_pin_i;
	logic serial_out_pin_o;
	logic [31:0] q;
	logic [10:0] fr;
	int n_errors = 0;
	int n_tests = 0;

	always #25 clk_sys_i = ~clk_sys_i;

	asp9_top dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .irq_enable_i(irq_enable_i), .irq_o(irq_o), .serial_in_pin_i(serial_in_pin_i),
		.serial_out_pin_o(serial_out_pin_o));
	asp9_remote #(.BIT_CLKS(BIT_CLKS)) rem_u (.clk_i(clk_sys_i), .line_i(serial_out_pin_o),
		.line_o(serial_in_pin_i));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic wb(input logic we, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_sys_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) n_errors++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_dat_i <= 32'h0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		wb(1'b0, a, 8'h00);
		chk(q, {24'h0, e});
	endtask

	task automatic t_regs;
		chk(serial_out_pin_o, 1'b1);
		rd(A_CTRL, 8'h40);
		rd(A_DATA, 8'h00);
		rd(12'h000, 8'h00);
		wb(1'b1, A_CTRL, 8'hbf);
		rd(A_CTRL, 8'hfc);
		wb(1'b1, A_CTRL, 8'h00);
		rd(A_CTRL, 8'h40);
	endtask

	task automatic t_tx8;
		wb(1'b1, A_CTRL, 8'h00);
		wb(1'b1, A_DATA, 8'ha5);
		rem_u.recv(1'b0, fr);
		chk(fr[9:0], {1'b1, 8'ha5, 1'b0});
		rd(A_CTRL, 8'h42);
		rd(A_DATA, 8'h00);
		chk(irq_o, 1'b1);
		irq_enable_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		chk(irq_o, 1'b0);
		irq_enable_i <= 1'b1;
		wb(1'b1, A_CTRL, 8'h00);
		rd(A_CTRL, 8'h40);
		chk(irq_o, 1'b0);
	endtask

	task automatic t_tx9;
		for (int b = 0; b < 2; b++) begin
			wb(1'b1, A_CTRL, {4'h8, b[0], 3'h0});
			wb(1'b1, A_DATA, 8'h3c ^ {8{b[0]}});
			rem_u.recv(1'b1, fr);
			chk(fr, {1'b1, b[0], 8'h3c ^ {8{b[0]}}, 1'b0});
			rd(A_CTRL, {4'hc, b[0], 3'h2});
		end
	endtask

	task automatic t_rx8;
		wb(1'b1, A_CTRL, 8'h10);
		rem_u.send(1'b0, 8'h3c, 1'b0, 1'b1);
		rd(A_CTRL, 8'h55);
		chk(irq_o, 1'b1);
		rd(A_DATA, 8'h3c);
		rem_u.send(1'b0, 8'h66, 1'b0, 1'b1);
		rd(A_DATA, 8'h3c);
		rd(A_CTRL, 8'h55);
		wb(1'b1, A_CTRL, 8'h30);
		rem_u.send(1'b0, 8'h77, 1'b0, 1'b0);
		rd(A_CTRL, 8'h70);
		wb(1'b1, A_CTRL, 8'h10);
		rem_u.send(1'b0, 8'h77, 1'b0, 1'b0);
		rd(A_CTRL, 8'h51);
		rd(A_DATA, 8'h77);
		wb(1'b1, A_CTRL, 8'h00);
		rem_u.send(1'b0, 8'h99, 1'b0, 1'b1);
		rd(A_CTRL, 8'h40);
		rd(A_DATA, 8'h77);
	endtask

	task automatic t_rx9;
		wb(1'b1, A_CTRL, 8'hb0);
		rem_u.send(1'b1, 8'h12, 1'b0, 1'b1);
		rd(A_CTRL, 8'hf0);
		rem_u.send(1'b1, 8'h34, 1'b1, 1'b1);
		rd(A_CTRL, 8'hf5);
		rd(A_DATA, 8'h34);
		wb(1'b1, A_CTRL, 8'h90);
		rem_u.send(1'b1, 8'h56, 1'b0, 1'b0);
		rd(A_CTRL, 8'hd1);
		rd(A_DATA, 8'h56);
	endtask

	task automatic final_report;
		$display("tests=%0d errors=%0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk_sys_i);
		sys_rst_i <= 1'b0;
		t_regs;
		wb(1'b1, A_RLD, RELOAD);
		wb(1'b1, A_RUN, 8'h01);
		t_tx8;
		t_tx9;
		t_rx8;
		t_rx9;
		final_report;
	end

	// Eleven frames of 11 bits need well under a third of this span
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		n_errors++;
		final_report;
	end
endmodule
